// File: rtl/cw_params.svh
`ifndef CW_PARAMS_SVH
`define CW_PARAMS_SVH
`define CW_CLK_NS 40
`define CW_SUB_BIT_NS 1000000
`define CW_SUB_CYC (`CW_SUB_BIT_NS / `CW_CLK_NS)
`define CW_HALF2K_NS 250000
`define CW_HALF2K_CYC (`CW_HALF2K_NS / `CW_CLK_NS)
`define CW_VER_TO_NS 10000000
`define CW_VER_TO_CYC (`CW_VER_TO_NS / `CW_CLK_NS)
`define CW_TOL_MIN_NS 40
`define CW_TOL_MIN_CYC ((`CW_TOL_MIN_NS + `CW_CLK_NS - 1) / `CW_CLK_NS)
`define CW_TOL_MAX_NS 100000000
`define CW_TOL_MAX_CYC (`CW_TOL_MAX_NS / `CW_CLK_NS)
`define CW_XBITS 3
`define CW_SUBS 5
`define CW_LAST_BIT 34
`define CW_ADDR_HI 31
`define CW_ADDR_LO 18
`define CW_DATA_W 18
`define CW_PAR_BIT 32
`define CW_BUF_DEPTH 512
`define CW_BUF_W 40
`endif

// File: rtl/cw_pkg.sv
`default_nettype none
package cw_pkg;
  typedef enum logic [1:0] {
    DEC_IDLE = 2'b00,
    DEC_RUN = 2'b01,
    DEC_END = 2'b10,
    DEC_WAIT = 2'b11
  } cw_dec_state_type;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_WVER = 2'b10,
    TX_WACC = 2'b11
  } cw_tx_state_type;
endpackage
`default_nettype wire

// File: rtl/cw_link_if.sv
`default_nettype none
interface cw_link_if;
  logic sub_bit;
  logic active;
  logic psk;
  logic ver_stb;
  logic acc_stb;
  logic rej_stb;
  logic [3:0] rej_reason;
  modport dev (
    input sub_bit, active, psk,
    output ver_stb, acc_stb, rej_stb, rej_reason
  );
  modport gnd (
    output sub_bit, active, psk,
    input ver_stb, acc_stb, rej_stb, rej_reason
  );
endinterface
`default_nettype wire

// File: rtl/cw_decoder.sv
`include "cw_params.svh"
`default_nettype none
module cw_decoder
  import cw_pkg::*;
#(
  parameter int unsigned SUB_CYC = `CW_SUB_CYC
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable
  input wire logic [13:0] dec_addr_i, // Configured decoder address
  input wire logic [4:0] pat_x_i, // Address bit pattern
  input wire logic [4:0] pat_one_i, // Binary one pattern
  input wire logic [4:0] pat_zero_i, // Binary zero pattern
  input wire logic fc_accept_i, // Flight computer accepts
  input wire logic fc_reject_i, // Flight computer rejects
  input wire logic [3:0] fc_reason_i, // Rejection reason
  output logic fca_valid_o, // Data strobe to adapter
  output logic [17:0] fca_data_o, // Data and control bits
  output logic discard_o, // Word discarded strobe
  cw_link_if.dev link // Uplink and telemetry
);
  localparam logic [15:0] LAST = 16'(SUB_CYC - 1);
  localparam logic [15:0] HALF = 16'(SUB_CYC / 2);

  cw_dec_state_type state_reg, state_next;
  logic [15:0] cyc_reg, cyc_next;
  logic [2:0] sub_reg, sub_next;
  logic [5:0] bit_reg, bit_next;
  logic [4:0] grp_reg, grp_next;
  logic [31:0] body_reg, body_next;
  logic err_reg, err_next;
  logic act_prev_reg;
  logic ver_reg, ver_next;
  logic acc_reg, acc_next;
  logic rej_reg, rej_next;
  logic [3:0] reason_reg, reason_next;
  logic fv_reg, fv_next;
  logic [17:0] fd_reg, fd_next;
  logic disc_reg, disc_next;
  logic [1:0] cls;

  // Returns {valid, value} for one five sub-bit group.
  function automatic logic [1:0] cw_class(
    input logic [4:0] g,
    input logic is_addr,
    input logic [4:0] px,
    input logic [4:0] p1,
    input logic [4:0] p0
  );
    logic [1:0] r;
    r = 2'b00;
    if (is_addr) begin
      r = {g == px, 1'b0};
    end else if (g == p1) begin
      r = 2'b11;
    end else if (g == p0) begin
      r = 2'b10;
    end
    return r;
  endfunction

  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    sub_next = sub_reg;
    bit_next = bit_reg;
    grp_next = grp_reg;
    body_next = body_reg;
    err_next = err_reg;
    ver_next = 1'b0;
    acc_next = 1'b0;
    rej_next = 1'b0;
    reason_next = reason_reg;
    fv_next = 1'b0;
    fd_next = fd_reg;
    disc_next = 1'b0;
    cls = 2'b00;
    case (state_reg)
      DEC_IDLE: begin
        if (link.active && !act_prev_reg) begin
          state_next = DEC_RUN;
          cyc_next = 16'h0001;
          sub_next = 3'h0;
          bit_next = 6'h00;
          err_next = 1'b0;
        end
      end
      DEC_RUN: begin
        if (!link.active) begin
          state_next = DEC_IDLE;
          disc_next = 1'b1;
        end else begin
          cyc_next = cyc_reg + 16'h0001;
          if (cyc_reg == HALF) begin
            grp_next = {grp_reg[3:0], link.sub_bit};
          end
          if (cyc_reg == LAST) begin
            cyc_next = 16'h0000;
            if (sub_reg == 3'(`CW_SUBS - 1)) begin
              sub_next = 3'h0;
              bit_next = bit_reg + 6'h01;
              cls = cw_class(grp_reg, bit_reg < 6'(`CW_XBITS),
                             pat_x_i, pat_one_i, pat_zero_i);
              if (!cls[1]) begin
                err_next = 1'b1;
              end
              if (bit_reg >= 6'(`CW_XBITS)) begin
                body_next = {body_reg[30:0], cls[0]};
              end
              if (bit_reg == 6'(`CW_LAST_BIT)) begin
                state_next = DEC_END;
              end
            end else begin
              sub_next = sub_reg + 3'h1;
            end
          end
        end
      end
      DEC_END: begin
        if (!err_reg && !link.active &&
            body_reg[`CW_ADDR_HI:`CW_ADDR_LO] == dec_addr_i) begin
          fv_next = 1'b1;
          fd_next = body_reg[`CW_DATA_W-1:0];
          ver_next = 1'b1;
          state_next = DEC_WAIT;
        end else begin
          disc_next = 1'b1;
          state_next = DEC_IDLE;
        end
      end
      DEC_WAIT: begin
        if (fc_accept_i) begin
          acc_next = 1'b1;
          state_next = DEC_IDLE;
        end else if (fc_reject_i) begin
          rej_next = 1'b1;
          reason_next = fc_reason_i;
          state_next = DEC_IDLE;
        end
      end
      default: begin
        state_next = DEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= DEC_IDLE;
      cyc_reg <= 16'h0000;
      sub_reg <= 3'h0;
      bit_reg <= 6'h00;
      grp_reg <= 5'h00;
      body_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
      act_prev_reg <= 1'b0;
      ver_reg <= 1'b0;
      acc_reg <= 1'b0;
      rej_reg <= 1'b0;
      reason_reg <= 4'h0;
      fv_reg <= 1'b0;
      fd_reg <= 18'h0_0000;
      disc_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      sub_reg <= sub_next;
      bit_reg <= bit_next;
      grp_reg <= grp_next;
      body_reg <= body_next;
      err_reg <= err_next;
      act_prev_reg <= link.active;
      ver_reg <= ver_next;
      acc_reg <= acc_next;
      rej_reg <= rej_next;
      reason_reg <= reason_next;
      fv_reg <= fv_next;
      fd_reg <= fd_next;
      disc_reg <= disc_next;
    end
  end

  assign link.ver_stb = ver_reg;
  assign link.acc_stb = acc_reg;
  assign link.rej_stb = rej_reg;
  assign link.rej_reason = reason_reg;
  assign fca_valid_o = fv_reg;
  assign fca_data_o = fd_reg;
  assign discard_o = disc_reg;
endmodule
`default_nettype wire

// File: rtl/cw_encoder.sv
`include "cw_params.svh"
`default_nettype none
module cw_encoder
  import cw_pkg::*;
#(
  parameter int unsigned SUB_CYC = `CW_SUB_CYC,
  parameter int unsigned HALF2K_CYC = `CW_HALF2K_CYC,
  parameter int unsigned VER_TO_CYC = `CW_VER_TO_CYC,
  parameter int unsigned TOL_MIN_CYC = `CW_TOL_MIN_CYC,
  parameter int unsigned TOL_MAX_CYC = `CW_TOL_MAX_CYC
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic ce_i, // Clock enable
  input wire logic [4:0] pat_x_i, // Address bit pattern
  input wire logic [4:0] pat_one_i, // Binary one pattern
  input wire logic [4:0] pat_zero_i, // Binary zero pattern
  input wire logic [1:0] src_sel_i, // Selected input source
  input wire logic [3:0] src_valid_i, // Word valid per source
  input wire logic [159:0] src_word_i, // Four 40-bit words
  output logic src_ready_o, // Buffer can take a word
  output logic parity_err_o, // Input check failed strobe
  output logic store_err_o, // Stored copy mismatch strobe
  output logic [9:0] buf_count_o, // Words buffered
  output logic word_done_o, // Word accepted strobe
  output logic retry_o, // Retransmission strobe
  output logic [3:0] reason_o, // Last rejection reason
  cw_link_if.gnd link // Uplink and telemetry
);
  localparam logic [15:0] LAST = 16'(SUB_CYC - 1);
  localparam logic [15:0] HLAST = 16'(HALF2K_CYC - 1);

  logic [`CW_BUF_W-1:0] mem [`CW_BUF_DEPTH];
  logic [8:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [9:0] cnt_reg, cnt_next;
  logic chk_reg, chk_next;
  logic [39:0] cpy_reg, cpy_next;
  logic rdy_reg, rdy_next, perr_reg, perr_next, serr_reg, serr_next;
  logic [39:0] in_word;
  logic take, pop;
  cw_tx_state_type st_reg, st_next;
  logic [15:0] cyc_reg, cyc_next, sc_cnt_reg, sc_cnt_next;
  logic [2:0] sub_reg, sub_next;
  logic [5:0] bit_reg, bit_next;
  logic [31:0] body_reg, body_next, tmr_reg, tmr_next;
  logic act_reg, act_next, sb_reg, sb_next;
  logic sc_reg, sc_next, psk_reg, psk_next;
  logic done_reg, done_next, rty_reg, rty_next;
  logic [3:0] rsn_reg, rsn_next;

  function automatic logic cw_sub(
    input logic [5:0] b,
    input logic [2:0] s,
    input logic [31:0] w,
    input logic [4:0] px,
    input logic [4:0] p1,
    input logic [4:0] p0
  );
    logic [4:0] p;
    p = px;
    if (b >= 6'(`CW_XBITS)) begin
      p = w[5'(6'(`CW_LAST_BIT) - b)] ? p1 : p0;
    end
    return p[3'(`CW_SUBS - 1) - s];
  endfunction

  assign in_word = src_word_i[src_sel_i * 40 +: 40];
  assign take = src_valid_i[src_sel_i] && rdy_reg;

  always_comb begin
    wr_next = wr_reg;
    chk_next = 1'b0;
    cpy_next = cpy_reg;
    perr_next = 1'b0;
    serr_next = 1'b0;
    if (chk_reg) begin
      if (mem[wr_reg] == cpy_reg) begin
        wr_next = wr_reg + 9'h001;
      end else begin
        serr_next = 1'b1;
      end
    end else if (take) begin
      if (^in_word[`CW_PAR_BIT:0] || |in_word[39:`CW_PAR_BIT+1]) begin
        perr_next = 1'b1;
      end else begin
        chk_next = 1'b1;
        cpy_next = in_word;
      end
    end
    cnt_next = cnt_reg + 10'(chk_reg && !serr_next) - 10'(pop);
    rdy_next = !chk_next && cnt_next < 10'(`CW_BUF_DEPTH - 1);
  end

  always_comb begin
    st_next = st_reg;
    cyc_next = cyc_reg;
    sub_next = sub_reg;
    bit_next = bit_reg;
    body_next = body_reg;
    tmr_next = tmr_reg + 32'h0000_0001;
    act_next = act_reg;
    sb_next = sb_reg;
    done_next = 1'b0;
    rty_next = 1'b0;
    rsn_next = rsn_reg;
    rd_next = rd_reg;
    pop = 1'b0;
    case (st_reg)
      TX_IDLE: begin
        if (cnt_reg != 10'h000) begin
          body_next = mem[rd_reg][31:0];
          st_next = TX_SEND;
          cyc_next = 16'h0000;
          sub_next = 3'h0;
          bit_next = 6'h00;
          act_next = 1'b1;
          sb_next = cw_sub(6'h00, 3'h0, body_next,
                           pat_x_i, pat_one_i, pat_zero_i);
        end
      end
      TX_SEND: begin
        cyc_next = cyc_reg + 16'h0001;
        if (cyc_reg == LAST) begin
          cyc_next = 16'h0000;
          if (sub_reg == 3'(`CW_SUBS - 1)) begin
            sub_next = 3'h0;
            bit_next = bit_reg + 6'h01;
          end else begin
            sub_next = sub_reg + 3'h1;
          end
          if (bit_reg == 6'(`CW_LAST_BIT) &&
              sub_reg == 3'(`CW_SUBS - 1)) begin
            act_next = 1'b0;
            sb_next = 1'b0;
            st_next = TX_WVER;
            tmr_next = 32'h0000_0000;
          end else begin
            sb_next = cw_sub(bit_next, sub_next, body_reg,
                             pat_x_i, pat_one_i, pat_zero_i);
          end
        end
      end
      TX_WVER: begin
        if (link.ver_stb) begin
          st_next = TX_WACC;
          tmr_next = 32'h0000_0000;
        end else if (link.acc_stb || link.rej_stb ||
                     tmr_reg == 32'(VER_TO_CYC)) begin
          st_next = TX_IDLE;
          rty_next = 1'b1;
        end
      end
      TX_WACC: begin
        if (link.acc_stb && tmr_reg >= 32'(TOL_MIN_CYC - 1)) begin
          st_next = TX_IDLE;
          done_next = 1'b1;
          pop = 1'b1;
          rd_next = rd_reg + 9'h001;
        end else if (link.acc_stb || link.rej_stb ||
                     tmr_reg == 32'(TOL_MAX_CYC - 1)) begin
          if (link.rej_stb) begin
            rsn_next = link.rej_reason;
          end
          st_next = TX_IDLE;
          rty_next = 1'b1;
        end
      end
      default: begin
        st_next = TX_IDLE;
      end
    endcase
    sc_cnt_next = sc_cnt_reg + 16'h0001;
    sc_next = sc_reg;
    if (sc_cnt_reg == HLAST) begin
      sc_cnt_next = 16'h0000;
      sc_next = !sc_reg;
    end
    psk_next = act_next & (sc_next ^ sb_next);
  end

  always_ff @(posedge ref_clk_i) begin
    if (ce_i && take && !chk_reg) begin
      mem[wr_reg] <= in_word;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_reg <= 9'h000;
      rd_reg <= 9'h000;
      cnt_reg <= 10'h000;
      chk_reg <= 1'b0;
      cpy_reg <= 40'h00_0000_0000;
      rdy_reg <= 1'b0;
      perr_reg <= 1'b0;
      serr_reg <= 1'b0;
      st_reg <= TX_IDLE;
      cyc_reg <= 16'h0000;
      sc_cnt_reg <= 16'h0000;
      sub_reg <= 3'h0;
      bit_reg <= 6'h00;
      body_reg <= 32'h0000_0000;
      tmr_reg <= 32'h0000_0000;
      act_reg <= 1'b0;
      sb_reg <= 1'b0;
      sc_reg <= 1'b0;
      psk_reg <= 1'b0;
      done_reg <= 1'b0;
      rty_reg <= 1'b0;
      rsn_reg <= 4'h0;
    end else if (ce_i) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      chk_reg <= chk_next;
      cpy_reg <= cpy_next;
      rdy_reg <= rdy_next;
      perr_reg <= perr_next;
      serr_reg <= serr_next;
      st_reg <= st_next;
      cyc_reg <= cyc_next;
      sc_cnt_reg <= sc_cnt_next;
      sub_reg <= sub_next;
      bit_reg <= bit_next;
      body_reg <= body_next;
      tmr_reg <= tmr_next;
      act_reg <= act_next;
      sb_reg <= sb_next;
      sc_reg <= sc_next;
      psk_reg <= psk_next;
      done_reg <= done_next;
      rty_reg <= rty_next;
      rsn_reg <= rsn_next;
    end
  end

  assign link.sub_bit = sb_reg;
  assign link.active = act_reg;
  assign link.psk = psk_reg;
  assign src_ready_o = rdy_reg;
  assign parity_err_o = perr_reg;
  assign store_err_o = serr_reg;
  assign buf_count_o = cnt_reg;
  assign word_done_o = done_reg;
  assign retry_o = rty_reg;
  assign reason_o = rsn_reg;
endmodule
`default_nettype wire

// File: verification/cw_link_props.sv
`default_nettype none
module cw_link_props #(
  parameter int unsigned SUB_CYC = 8
) (
  input wire logic ref_clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic sub_bit, // Sub-bit level
  input wire logic active, // Word in flight
  input wire logic psk, // Modulated line
  input wire logic ver_stb, // Address verified strobe
  input wire logic acc_stb, // Word accepted strobe
  input wire logic rej_stb, // Word rejected strobe
  input wire logic [3:0] rej_reason // Rejection reason
);
  localparam int WORD_CYC = 175 * SUB_CYC;
  logic [31:0] run_reg;
  logic [31:0] run_next;
  logic ver_seen_reg;
  logic ver_seen_next;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  // The verify flag survives a resend, because a late answer may overlap it.
  always_comb begin
    run_next = active ? run_reg + 32'h0000_0001 : 32'h0000_0000;
    ver_seen_next = ver_seen_reg;
    if (acc_stb || rej_stb) begin
      ver_seen_next = 1'b0;
    end else if (ver_stb) begin
      ver_seen_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      run_reg <= 32'h0000_0000;
      ver_seen_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      ver_seen_reg <= ver_seen_next;
    end
  end

  AST_VER_PULSE: assert property (ver_stb |=> !ver_stb)
    else $error("verify strobe longer than one cycle");
  AST_ACC_PULSE: assert property (acc_stb |=> !acc_stb [*2])
    else $error("acceptance strobe not a single pulse");
  // The decoder ends the word at the edge that drops active, so verify follows
  // one edge later.
  AST_VER_TIMING: assert property (ver_stb |-> !$past(active, 1)
    && $past(active, 2))
    else $error("verify strobe not one cycle after word end");
  AST_ACC_AFTER_VER: assert property (acc_stb |-> ver_seen_reg)
    else $error("acceptance without prior verify");
  AST_REJ_AFTER_VER: assert property (rej_stb |-> ver_seen_reg
    && !acc_stb)
    else $error("rejection without verify or with acceptance");
  AST_PSK_IDLE: assert property (!active |-> !psk)
    else $error("modulated line busy outside a word");
  AST_SUB_EDGE: assert property (active && $past(active)
    && $changed(sub_bit) |-> run_reg % SUB_CYC == 0)
    else $error("sub-bit changed inside a sub-bit slot");
  AST_WORD_LEN: assert property ($fell(active) |-> run_reg == WORD_CYC)
    else $error("word length not 175 sub-bits");
endmodule
`default_nettype wire

// File: verification/uplink_command_word_acceptance_tb.sv
`default_nettype none
module uplink_command_word_acceptance_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SUB = 8;
  localparam logic [13:0] DEC_ADDR = 14'h135A;
  localparam int LIMIT = 40000;
  typedef struct packed {
    logic [17:0] data;
    logic rej;
    logic bad;
    logic [1:0] pat;
  } cw_tb_row_type;
  cw_tb_row_type rows [5] = '{'{18'h0_0000, 1'h0, 1'h0, 2'h0},
    '{18'h3_FFFF, 1'h0, 1'h0, 2'h1}, '{18'h1_5A5A, 1'h1, 1'h0, 2'h2},
    '{18'h2_A5A5, 1'h0, 1'h1, 2'h0}, '{18'h0_C3C3, 1'h1, 1'h1, 2'h1}};
  logic [14:0] pats [3] = '{15'h3BE0, 15'h5553, 15'h70F9};
  logic ref_clk_i, rst_i, ce, fc_accept, fc_reject;
  logic [14:0] pat_set;
  logic [13:0] dec_addr;
  logic [3:0] fc_reason, src_valid, reason_o;
  logic [1:0] src_sel;
  logic [159:0] src_word;
  logic fca_valid_o, discard_o, src_ready_o, parity_err_o, store_err_o;
  logic word_done_o, retry_o;
  logic [17:0] fca_data_o;
  logic [9:0] buf_count_o;
  int checked, n_mismatch, cycles, n_fwd, exp_count;

  cw_link_if link_bus ();
  cw_encoder #(.SUB_CYC(SUB), .HALF2K_CYC(3), .VER_TO_CYC(200),
    .TOL_MIN_CYC(1), .TOL_MAX_CYC(50)) i_cw_encoder (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
    .pat_x_i(pat_set[14:10]), .pat_one_i(pat_set[9:5]),
    .pat_zero_i(pat_set[4:0]), .src_sel_i(src_sel), .src_valid_i(src_valid),
    .src_word_i(src_word), .src_ready_o(src_ready_o),
    .parity_err_o(parity_err_o), .store_err_o(store_err_o),
    .buf_count_o(buf_count_o), .word_done_o(word_done_o),
    .retry_o(retry_o), .reason_o(reason_o), .link(link_bus.gnd));
  cw_decoder #(.SUB_CYC(SUB)) i_cw_decoder (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
    .dec_addr_i(dec_addr), .pat_x_i(pat_set[14:10]),
    .pat_one_i(pat_set[9:5]), .pat_zero_i(pat_set[4:0]),
    .fc_accept_i(fc_accept), .fc_reject_i(fc_reject),
    .fc_reason_i(fc_reason), .fca_valid_o(fca_valid_o),
    .fca_data_o(fca_data_o), .discard_o(discard_o), .link(link_bus.dev));
  cw_link_props #(.SUB_CYC(SUB)) i_cw_link_props (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sub_bit(link_bus.sub_bit),
    .active(link_bus.active), .psk(link_bus.psk),
    .ver_stb(link_bus.ver_stb), .acc_stb(link_bus.acc_stb),
    .rej_stb(link_bus.rej_stb), .rej_reason(link_bus.rej_reason));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (fca_valid_o === 1'b1) n_fwd++;
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: pick = fca_valid_o;
      1: pick = discard_o;
      2: pick = retry_o;
      default: pick = link_bus.active;
    endcase
  endfunction

  // Every wait is bounded so that a lost pulse shows as a mismatch.
  task automatic wait_sig(input int w);
    int n;
    n = 0;
    while (pick(w) !== 1'b1 && n < 3000) begin
      @(negedge ref_clk_i);
      n++;
    end
    check(pick(w), 1'b1);
  endtask

  function automatic logic [39:0] mk(input logic [31:0] b);
    mk = {7'h00, ^b, b};
  endfunction

  task automatic do_reset;
    rst_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    check(buf_count_o, 10'h000);
    check({src_ready_o, link_bus.active, link_bus.ver_stb}, 3'h0);
    rst_i = 1'b0;
    exp_count = 0;
  endtask

  // Other sources offer corrupt words, so only the selected one may land.
  task automatic push(input logic [39:0] w, input logic [1:0] s,
    input logic ok);
    int n;
    n = 0;
    while (src_ready_o !== 1'b1 && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    src_sel = s;
    src_word = {4{~w}};
    src_word[40 * int'(s) +: 40] = w;
    src_valid = 4'hF;
    @(negedge ref_clk_i);
    src_valid = 4'h0;
    check(parity_err_o, !ok);
    if (ok) check(src_ready_o, 1'b0);
    @(negedge ref_clk_i);
    if (ok) exp_count++;
    check(buf_count_o, exp_count);
    check(store_err_o, 1'b0);
  endtask

  task automatic wire_check(input logic [31:0] body);
    logic [4:0] p;
    wait_sig(3);
    repeat (SUB / 2) @(negedge ref_clk_i);
    for (int i = 0; i < 175; i++) begin
      p = i < 15 ? pat_set[14:10] : body[31 - (i / 5 - 3)] ? pat_set[9:5]
        : pat_set[4:0];
      check(link_bus.sub_bit, p[4 - i % 5]);
      if (i < 174) repeat (SUB) @(negedge ref_clk_i);
    end
  endtask

  task automatic answer(input logic acc, input logic [3:0] rsn);
    fc_accept = acc;
    fc_reject = !acc;
    fc_reason = rsn;
    @(negedge ref_clk_i);
    fc_accept = 1'b0;
    fc_reject = 1'b0;
    check(acc ? link_bus.acc_stb : link_bus.rej_stb, 1'b1);
  endtask

  task automatic run_word(input cw_tb_row_type r, input logic chk,
    input logic [3:0] rsn);
    int f;
    f = n_fwd;
    if (chk) wire_check({DEC_ADDR, r.data});
    if (r.bad) begin
      wait_sig(1);
      check(n_fwd, f);
      dec_addr = DEC_ADDR;
      wait_sig(2);
    end
    wait_sig(0);
    check(fca_data_o, r.data);
    check(link_bus.ver_stb, 1'b1);
    if (r.rej) begin
      answer(1'b0, rsn);
      check(link_bus.rej_reason, rsn);
      @(negedge ref_clk_i);
      check({retry_o, reason_o}, {1'b1, rsn});
      wait_sig(0);
      check(fca_data_o, r.data);
    end
    answer(1'b1, rsn);
    @(negedge ref_clk_i);
    check(word_done_o, 1'b1);
    exp_count--;
    repeat (2) @(negedge ref_clk_i);
    check(buf_count_o, exp_count);
  endtask

  initial begin
    {rst_i, fc_accept, fc_reject, fc_reason, src_valid} = 11'h400;
    {src_sel, src_word, checked, n_mismatch, cycles, n_fwd} = '0;
    ce = 1'b1;
    pat_set = pats[0];
    dec_addr = DEC_ADDR;
    @(negedge ref_clk_i);
    do_reset;
    foreach (rows[i]) begin
      pat_set = pats[rows[i].pat];
      if (rows[i].bad) dec_addr = ~DEC_ADDR;
      push(mk({DEC_ADDR, rows[i].data}), 2'(i), 1'b1);
      run_word(rows[i], 1'b1, 4'(i + 3));
    end
    // Wrong parity, then a nonzero spare field.
    push({7'h00, 1'b1, 32'h0000_0000}, 2'h1, 1'b0);
    push({7'h01, 1'b0, 32'h0000_0000}, 2'h2, 1'b0);
    push(mk({DEC_ADDR, rows[1].data}), 2'h0, 1'b1);
    push(mk({DEC_ADDR, rows[0].data}), 2'h3, 1'b1);
    run_word(rows[1], 1'b0, 4'h1);
    run_word(rows[0], 1'b0, 4'h2);
    for (int k = 0; k < 511; k++) push(mk(32'(k)), 2'(k), 1'b1);
    src_valid = 4'hF;
    repeat (3) @(negedge ref_clk_i);
    src_valid = 4'h0;
    check({src_ready_o, buf_count_o}, {1'b0, 10'h1FF});
    do_reset;
    push(mk({DEC_ADDR, rows[2].data}), 2'h2, 1'b1);
    run_word(rows[2], 1'b1, 4'hE);
    // A low clock enable must hold the source stage, so no word is taken.
    ce = 1'b0;
    src_sel = 2'h3;
    src_word = {4{mk({DEC_ADDR, rows[3].data})}};
    src_valid = 4'hF;
    repeat (4) @(negedge ref_clk_i);
    check({src_ready_o, buf_count_o}, {1'b1, 10'h000});
    ce = 1'b1;
    @(negedge ref_clk_i);
    src_valid = 4'h0;
    check(src_ready_o, 1'b0);
    // A late computer answer lets the ground monitor time out and resend.
    wait_sig(0);
    check(fca_data_o, rows[3].data);
    wait_sig(2);
    answer(1'b1, 4'h0);
    wait_sig(0);
    check(fca_data_o, rows[3].data);
    answer(1'b1, 4'h0);
    @(negedge ref_clk_i);
    check(word_done_o, 1'b1);
    stop_test;
  end
endmodule
`default_nettype wire
